// file: pkg/hfa_pkg.sv
// package of constants and types for the half-flash converter host controller
package hfa_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // host timing figures in ns as printed
  localparam int unsigned WR_LOW_MIN_NS = 600;
  localparam int unsigned WR_LOW_MAX_NS = 50000;
  localparam int unsigned WR_TO_RD_NS   = 600;
  localparam int unsigned TIMEOUT_NS    = 800;
  localparam int unsigned ZERO_PHASE_NS = 500;
  // least times round up, longest time rounds down
  localparam int unsigned WR_LOW_CYC  = (WR_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_MAX_CYC  = (WR_LOW_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WR_RD_CYC   = (WR_TO_RD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ZERO_CYC    = (ZERO_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W       = 12;
  localparam int unsigned DATA_W      = 8;
  // safety limit in both modes for a conversion that never reports done
  localparam int unsigned RD_LIMIT_CYC = 4 * TIMEOUT_CYC;

  typedef enum logic [2:0] {
    HFA_IDLE,
    HFA_WR_LOW,
    HFA_WR_WAIT,
    HFA_RD_LOW,
    HFA_RECOVER
  } hfa_state_type;

  typedef struct packed {
    hfa_state_type        state;
    logic [CNT_W-1:0]     cnt;
    logic                 cs_n;
    logic                 rd_n;
    logic                 wr_n;
    logic                 mode;
    logic                 early;
    logic [DATA_W-1:0]    data;
    logic                 ovr;
    logic                 valid;
    logic                 busy;
    logic                 timeout;
    logic [1:0]           done_s;
    logic [1:0]           rdy_s;
    logic [1:0][DATA_W:0] bus_s;
  } hfa_regs_type;
endpackage

// file: design/hfa_host.sv
// host controller that runs conversions on a half-flash converter through its pins
//
// Contract
// - host straps mode low or high
// - read-only: hold read low until data
// - write low at least 600 ns
// - read no sooner than 600 ns after write
// - stand-alone: chip select, read held low; the controller has no stand-alone mode, cs_n and rd_n pulse per conversion
// - write low pulse at most 50 us
// - wait 500 ns before next conversion
// - chip select low for any strobe
`timescale 1ns/1ps
module hfa_host
  import hfa_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // user side
  input  wire logic                      start,
  input  wire logic                      mode_sel,
  input  wire logic                      early_read,
  output logic                           busy,
  output logic                           result_valid,
  output logic [hfa_pkg::DATA_W-1:0]     result,
  output logic                           result_ovr,
  output logic                           timeout_err,
  // strobes toward the converter
  output logic                           cs_n,
  output logic                           rd_n,
  output logic                           wr_n,
  output logic                           mode,
  // answers from the converter
  input  wire logic                      done_n,
  input  wire logic                      rdy_in,
  input  wire logic [hfa_pkg::DATA_W-1:0] result_bus,
  input  wire logic                      overrange_n
);
  import hfa_pkg::*;

  hfa_regs_type      r;
  hfa_regs_type      n;

  // synchronised pins
  logic              done_seen;
  logic              rdy_seen;
  logic [DATA_W-1:0] bus_data;
  logic              bus_ovr;

  // decoded conditions
  logic              early_go;
  logic              wr_end;
  logic              wait_over;
  logic              capture_go;
  logic              read_over;
  logic              recover_end;

  // done, busy and the data pins each pass two flops; only the second stage is read
  assign done_seen = ~r.done_s[1];
  assign rdy_seen  = r.rdy_s[1];
  assign bus_data  = r.bus_s[1][DATA_W-1:0];
  assign bus_ovr   = ~r.bus_s[1][DATA_W];

  // the write pulse is fixed between the least and the longest width
  assign wr_end = (r.cnt == CNT_W'(WR_LOW_CYC - 1));

  // early read after the least spacing, else wait for done
  assign early_go  = r.early && (r.cnt >= CNT_W'(WR_RD_CYC - 1));
  assign wait_over = (r.cnt == CNT_W'(RD_LIMIT_CYC));

  // two cycles into the read the synced data belongs to this read, not the last one
  // rdy_in counts only in read-only mode: released busy means the latch is loaded
  assign capture_go = done_seen && (r.cnt >= CNT_W'(2)) && (r.mode || rdy_seen);
  assign read_over  = (r.cnt == CNT_W'(RD_LIMIT_CYC));

  // upper bank zeroing must finish before the next start
  assign recover_end = (r.cnt == CNT_W'(ZERO_CYC - 1));

  always_comb begin
    n = r;
    n.done_s = {r.done_s[0], done_n};
    n.rdy_s  = {r.rdy_s[0], rdy_in};
    n.bus_s  = {r.bus_s[0], {overrange_n, result_bus}};
    // valid is a one-cycle pulse
    n.valid  = 1'b0;
    unique case (r.state)
      // idle: strobes released; cs_n and rd_n pulse per conversion, never tied low
      HFA_IDLE: begin
        n.cs_n = 1'b1;
        n.rd_n = 1'b1;
        n.wr_n = 1'b1;
        n.busy = 1'b0;
        n.cnt  = '0;
        // a start while busy never reaches here, so it is dropped
        if (start) begin
          // mode and early choice latch with start and hold for the whole conversion
          n.mode    = mode_sel;
          n.early   = early_read;
          n.busy    = 1'b1;
          n.timeout = 1'b0;
          n.cs_n    = 1'b0;
          if (mode_sel) begin
            n.wr_n  = 1'b0;
            n.state = HFA_WR_LOW;
          end else begin
            n.rd_n  = 1'b0;
            n.state = HFA_RD_LOW;
          end
        end
      end

      // write low: the device compares the upper nibble meanwhile
      HFA_WR_LOW: begin
        n.cnt = r.cnt + 1'b1;
        // fixed width sits between the least and the longest pulse
        if (wr_end) begin
          n.wr_n  = 1'b1;
          n.cnt   = '0;
          n.state = HFA_WR_WAIT;
        end
      end

      // write high: the lower nibble is being compared
      HFA_WR_WAIT: begin
        n.cnt = r.cnt + 1'b1;
        if (early_go || done_seen) begin
          n.rd_n  = 1'b0;
          n.cnt   = '0;
          n.state = HFA_RD_LOW;
        end else if (wait_over) begin
          // no done: release select so the device drops the conversion
          n.timeout = 1'b1;
          n.cs_n    = 1'b1;
          n.cnt     = '0;
          n.state   = HFA_RECOVER;
        end
      end

      // read low: wait for done, then take the synchronised data
      HFA_RD_LOW: begin
        n.cnt = r.cnt + 1'b1;
        // read stays low until done shows data latched; the two flop delay covers access
        if (capture_go) begin
          n.data  = bus_data;
          n.ovr   = bus_ovr;
          n.valid = 1'b1;
          n.rd_n  = 1'b1;
          n.cs_n  = 1'b1;
          n.cnt   = '0;
          n.state = HFA_RECOVER;
        end else if (read_over) begin
          // no done: give up, release both strobes and flag the error
          n.timeout = 1'b1;
          n.rd_n    = 1'b1;
          n.cs_n    = 1'b1;
          n.cnt     = '0;
          n.state   = HFA_RECOVER;
        end
      end

      // recovery: select stays high for the zeroing time
      HFA_RECOVER: begin
        n.cnt = r.cnt + 1'b1;
        if (recover_end) begin
          n.cnt   = '0;
          n.busy  = 1'b0;
          n.state = HFA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // every strobe released so the device sees no request during reset
      r.state   <= HFA_IDLE;
      r.cnt     <= '0;
      r.cs_n    <= 1'b1;
      r.rd_n    <= 1'b1;
      r.wr_n    <= 1'b1;
      r.mode    <= 1'b0;
      r.early   <= 1'b0;
      r.data    <= '0;
      r.ovr     <= 1'b0;
      r.valid   <= 1'b0;
      r.busy    <= 1'b0;
      r.timeout <= 1'b0;
      r.done_s  <= 2'b11;
      r.rdy_s   <= 2'b11;
      r.bus_s   <= '0;
    end else begin
      r <= n;
    end
  end

  // strobes toward the device
  assign cs_n         = r.cs_n;
  assign rd_n         = r.rd_n;
  assign wr_n         = r.wr_n;
  assign mode         = r.mode;

  // status and results toward the user
  assign busy         = r.busy;
  assign result_valid = r.valid;
  assign result       = r.data;
  assign result_ovr   = r.ovr;
  assign timeout_err  = r.timeout;
endmodule

// file: sim/hfa_host_asserts.sv
// checker of host strobe timing toward the converter
`timescale 1ns/1ps
module hfa_host_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic mode,
  input wire logic done_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_md; !cs_n && !$fell(cs_n) |-> $stable(mode); endproperty
  a_md: assert property (p_md) else $error("mode moved");
  property p_rd; !mode && !rd_n && done_n |=> !rd_n; endproperty
  a_rd: assert property (p_rd) else $error("read left early");
  property p_wl; $rose(wr_n) |-> !$past(wr_n, 24); endproperty
  a_wl: assert property (p_wl) else $error("write too short");
  property p_wr; $fell(rd_n) && mode |-> $past(wr_n, 24); endproperty
  a_wr: assert property (p_wr) else $error("read too soon");
  property p_sa; !wr_n |-> mode && rd_n; endproperty
  a_sa: assert property (p_sa) else $error("write out of mode");
  // tighter than the real limit, a delay range cannot reach it
  property p_wm; $fell(wr_n) |-> ##[1:1000] wr_n; endproperty
  a_wm: assert property (p_wm) else $error("write too long");
  property p_rc; $fell(cs_n) |-> $past(cs_n, 20); endproperty
  a_rc: assert property (p_rc) else $error("recovery short");
  property p_cs; !rd_n || !wr_n |-> !cs_n; endproperty
  a_cs: assert property (p_cs) else $error("strobe unselected");
  c_rd: cover property ($fell(rd_n) && !mode);
  c_wr: cover property ($rose(wr_n));
  c_bs: cover property ($fell(busy));
endmodule
bind hfa_host hfa_host_asserts u_chk (.clk_sys, .rst, .busy, .cs_n, .rd_n, .wr_n, .mode, .done_n);

// file: sim/hfa_dev_model.sv
// behavioural converter on the far side of the host controller
`timescale 1ns/1ps
module hfa_dev_model (
  // host strobes and value to convert, bit 8 overrange
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       mode,
  input  wire logic [8:0] val,
  input  wire logic       mute,
  // answers
  output logic            done_n,
  output logic            rdy_in,
  output logic [7:0]      result_bus,
  output logic            overrange_n
);
  logic [8:0] lat = 9'h000;
  logic       done = 1'b0;
  always @(negedge rd_n) if (!cs_n && !mode) begin
    #1600;
    if (!mute) begin
      lat = val;
      done = 1'b1;
    end
  end
  always @(posedge wr_n) if (!cs_n && mode) begin
    fork
      #800;
      @(negedge rd_n);
    join_any
    disable fork;
    if (!mute) begin
      lat = val;
      done = 1'b1;
    end
  end
  always @(posedge rd_n or posedge cs_n) done = 1'b0;
  assign done_n = ~done;
  assign rdy_in = !cs_n && !mode && !done ? 1'b0 : 1'b1;
  // released bus shows the inverse so a stale capture is caught
  assign result_bus = !cs_n && !rd_n && done ? lat[7:0] : ~lat[7:0];
  assign overrange_n = ~lat[8];
endmodule

// file: sim/hfa_host_tb_top.sv
// self-checking bench for the half-flash host controller
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module hfa_host_tb_top;
  import hfa_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, start = 1'b0, mode_sel = 1'b0, early_read = 1'b0;
  logic [8:0] val = 9'h000;
  logic       mute = 1'b0;
  logic       busy, result_valid, result_ovr, timeout_err, cs_n, rd_n, wr_n, mode;
  logic       done_n, rdy_in, overrange_n;
  logic [7:0] result, result_bus;
  int         n_fail = 0, total_checks = 0, n_cyc;
  always #12.5 clk_sys = ~clk_sys;
  hfa_host i_dut (.clk_sys, .rst, .start, .mode_sel, .early_read, .busy, .result_valid,
    .result, .result_ovr, .timeout_err, .cs_n, .rd_n, .wr_n, .mode, .done_n, .rdy_in,
    .result_bus, .overrange_n);
  hfa_dev_model i_dev (.cs_n, .rd_n, .wr_n, .mode, .val, .mute, .done_n, .rdy_in, .result_bus,
    .overrange_n);
  task automatic final_report();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic conv(input logic m, input logic e, input logic [8:0] v);
    n_cyc = 0;
    val = v;
    mode_sel = m;
    early_read = e;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    while (result_valid !== 1'b1 && n_cyc < 300) begin
      @(negedge clk_sys);
      n_cyc++;
    end
    if (n_cyc == 300) begin
      n_fail++;
      final_report();
    end
    `CHK(result, v[7:0])
    `CHK(result_ovr, v[8])
    `CHK(timeout_err, 1'b0)
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(negedge clk_sys);
    `CHK(busy, 1'b0)
  endtask
  task automatic t_read();
    conv(1'b0, 1'b0, 9'h05a);
    `CHK(n_cyc >= 64, 1'b1)
    $display("read-only test ends");
  endtask
  task automatic t_early();
    conv(1'b1, 1'b1, 9'h1a5);
    `CHK(n_cyc < 57, 1'b1)
    $display("early read test ends");
  endtask
  task automatic t_late();
    conv(1'b1, 1'b0, 9'h0c3);
    `CHK(n_cyc >= 57, 1'b1)
    $display("late read test ends");
  endtask
  task automatic t_timeout();
    mute = 1'b1;
    mode_sel = 1'b1;
    early_read = 1'b0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    for (int i = 0; i < 300 && timeout_err !== 1'b1; i++) @(negedge clk_sys);
    `CHK(timeout_err, 1'b1)
    `CHK(result_valid, 1'b0)
    for (int i = 0; i < 40 && busy === 1'b1; i++) @(negedge clk_sys);
    `CHK(busy, 1'b0)
    mute = 1'b0;
    $display("timeout test ends");
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (24) @(negedge clk_sys);
    t_read();
    t_early();
    t_late();
    t_timeout();
    final_report();
  end
endmodule
